// *** ulpd_baud_gen.sv ***
`timescale 1ns/1ps

module ulpd_baud_gen
   import ulpd_pkg::*;
#(
   parameter int DIV_W = ULPD_DIV_W
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_srst,
   // Divisor.
   input wire logic [DIV_W-1:0] i_divisor,
   input wire logic i_restart,
   // Baud output.
   output ulpd_baud_t o_baud
);

   logic [DIV_W-1:0] div_cnt_r;
   logic [DIV_W-1:0] div_cnt_nxt;
   logic [3:0] ovs_cnt_r;
   logic [3:0] ovs_cnt_nxt;
   ulpd_baud_t baud_r;
   ulpd_baud_t baud_nxt;
   logic enabled;

   assign enabled = (i_divisor != '0);

   always_comb begin
      div_cnt_nxt = div_cnt_r;
      ovs_cnt_nxt = ovs_cnt_r;
      baud_nxt = '0;
      baud_nxt.baud_en = enabled;
      if (!enabled || i_restart) begin
         div_cnt_nxt = '0;
         ovs_cnt_nxt = '0;
      end else if (div_cnt_r >= i_divisor - DIV_W'(1)) begin
         // One sample tick every divisor cycles, one baud tick every sixteen.
         div_cnt_nxt = '0;
         baud_nxt.sample_tick = 1'b1;
         ovs_cnt_nxt = ovs_cnt_r + 4'h1;
         if (ovs_cnt_r == ULPD_OVS_LAST) begin
            ovs_cnt_nxt = '0;
            baud_nxt.baud_tick = 1'b1;
         end
      end else begin
         div_cnt_nxt = div_cnt_r + DIV_W'(1);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         div_cnt_r <= '0;
         ovs_cnt_r <= '0;
         baud_r <= '0;
      end else begin
         div_cnt_r <= div_cnt_nxt;
         ovs_cnt_r <= ovs_cnt_nxt;
         baud_r <= baud_nxt;
      end
   end

   assign o_baud = baud_r;

endmodule // ulpd_baud_gen

// *** ulpd_checker.sv ***
`timescale 1ns/1ps
module ulpd_chk
   import ulpd_pkg::*;
(
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_srst,
   // Watched ports.
   input wire logic [31:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [15:0] o_rdata,
   input wire logic i_divisor_latch_access_bit,
   input wire logic o_lp_baud_en,
   input wire logic o_lp_baud_tick,
   input wire logic o_lp_sample_tick,
   input wire logic o_pulse_detect_en,
   input wire logic o_settling
);
   wire lk = !i_divisor_latch_access_bit;
   wire acc = i_wr && !lk && (i_addr == ULPD_LOW_BYTE_ADDR || i_addr == ULPD_HIGH_BYTE_ADDR);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_srst);
   a_rsvd_zero: assert property (o_rdata[15:8] == 8'h00) else $error("rsvd set");
   a_rd_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000) else $error("stray");
   a_rd_gated: assert property ($past(i_rd && lk) |-> o_rdata == 16'h0000) else $error("gate");
   a_det_follow: assert property (o_pulse_detect_en == o_lp_baud_en) else $error("det");
   a_off_quiet:
      assert property (!o_lp_baud_en |-> !o_lp_sample_tick && !o_lp_baud_tick) else $error("off");
   a_tick_gap: assert property (o_lp_baud_tick |=> (!o_lp_baud_tick) [*8]) else $error("gap");
   a_settle_hold: assert property (acc |=> o_settling [*8]) else $error("settle");
   a_settle_cause: assert property ($rose(o_settling) |-> $past(acc)) else $error("cause");
   a_reset_off:
      assert property ($past(i_srst) |-> !o_lp_baud_en && !o_settling) else $error("rst");
endmodule // ulpd_chk
bind ulpd_divisor ulpd_chk u_chk (.i_clk, .i_srst, .i_addr, .i_wr, .i_rd, .o_rdata,
   .i_divisor_latch_access_bit, .o_lp_baud_en, .o_lp_baud_tick, .o_lp_sample_tick,
   .o_pulse_detect_en, .o_settling);

// *** ulpd_divisor.sv ***
`timescale 1ns/1ps

module ulpd_divisor
   import ulpd_pkg::*;
#(
   parameter int DIV_W = ULPD_DIV_W
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_srst,
   // Register port.
   input wire logic [31:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   // Line control register bit 7.
   input wire logic i_divisor_latch_access_bit,
   // Low-power baud outputs to the infrared receiver.
   output logic o_lp_baud_en,
   output logic o_lp_baud_tick,
   output logic o_lp_sample_tick,
   output logic o_pulse_detect_en,
   output logic o_settling
);

   ////////////////////////////////////////////////////////////////////////////
   // Divisor latches.

   logic [7:0] lp_divisor_low_latch_r;
   logic [7:0] lp_divisor_low_latch_nxt;
   logic [7:0] lp_divisor_high_latch_r;
   logic [7:0] lp_divisor_high_latch_nxt;
   logic [15:0] rdata_r;
   logic [15:0] rdata_nxt;
   logic hit_low;
   logic hit_high;

   // Outside the access window the latches are invisible: writes are dropped
   // and reads return zero, so normal data registers can share the offsets.
   assign hit_low = (i_addr == ULPD_LOW_BYTE_ADDR) && i_divisor_latch_access_bit;
   assign hit_high = (i_addr == ULPD_HIGH_BYTE_ADDR) && i_divisor_latch_access_bit;

   always_comb begin
      lp_divisor_low_latch_nxt = lp_divisor_low_latch_r;
      lp_divisor_high_latch_nxt = lp_divisor_high_latch_r;
      rdata_nxt = '0;
      if (i_wr && hit_low) begin
         lp_divisor_low_latch_nxt = i_wdata[ULPD_FIELD_LSB +: ULPD_FIELD_W];
      end
      if (i_wr && hit_high) begin
         lp_divisor_high_latch_nxt = i_wdata[ULPD_FIELD_LSB +: ULPD_FIELD_W];
      end
      if (i_rd && hit_low) begin
         rdata_nxt = {8'h00, lp_divisor_low_latch_r};
      end else if (i_rd && hit_high) begin
         rdata_nxt = {8'h00, lp_divisor_high_latch_r};
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         lp_divisor_low_latch_r <= ULPD_LATCH_RST;
         lp_divisor_high_latch_r <= ULPD_LATCH_RST;
         rdata_r <= '0;
      end else begin
         lp_divisor_low_latch_r <= lp_divisor_low_latch_nxt;
         lp_divisor_high_latch_r <= lp_divisor_high_latch_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign o_rdata = rdata_r;

   ////////////////////////////////////////////////////////////////////////////
   // Settling window after a divisor write.

   logic [3:0] settle_cnt_r;
   logic [3:0] settle_cnt_nxt;
   logic div_write;

   assign div_write = i_wr && (hit_low || hit_high);

   // Software is meant to honour the wait; the flag only lets it poll.
   always_comb begin
      settle_cnt_nxt = settle_cnt_r;
      if (div_write) begin
         settle_cnt_nxt = ULPD_SETTLE_LOAD;
      end else if (settle_cnt_r != 4'h0) begin
         settle_cnt_nxt = settle_cnt_r - 4'h1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         settle_cnt_r <= '0;
      end else begin
         settle_cnt_r <= settle_cnt_nxt;
      end
   end

   assign o_settling = (settle_cnt_r != 4'h0);

   ////////////////////////////////////////////////////////////////////////////
   // Baud generator.

   ulpd_baud_t baud;

   ulpd_baud_gen #(
      .DIV_W(DIV_W)
   ) u_baud (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_divisor({lp_divisor_high_latch_r, lp_divisor_low_latch_r}),
      .i_restart(div_write),
      .o_baud(baud)
   );

   assign o_lp_baud_en = baud.baud_en;
   assign o_lp_baud_tick = baud.baud_tick;
   assign o_lp_sample_tick = baud.sample_tick;
   assign o_pulse_detect_en = baud.baud_en;

endmodule // ulpd_divisor

// *** ulpd_divisor_bench.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; $display("[ERR] %0t bad", $time); end end
module ulpd_divisor_bench;
   import ulpd_pkg::*;
   logic i_clk = 0, i_srst = 1, i_wr = 0, i_rd = 0, lb = 1;
   logic [31:0] i_addr = '0;
   logic [15:0] i_wdata = '0;
   logic [15:0] o_rdata;
   logic en, bt, st, pd, sl;
   int n_fail = 0, cmp_count = 0, n, s;
   // Nearest divisor for the target rate; choosing it is software's job, not the block's.
   int lp_div = (ULPD_CLK_HZ + ULPD_OVERSAMPLE * ULPD_TARGET_BAUD / 2) /
      (ULPD_OVERSAMPLE * ULPD_TARGET_BAUD);
   // Each row: address, write data, expected byte; the last rows leave a divisor of 2.
   logic [55:0] rows [4] = '{{ULPD_LOW_BYTE_ADDR, 16'h00A5, 8'hA5},
      {ULPD_HIGH_BYTE_ADDR, 16'hFF3C, 8'h3C}, {ULPD_LOW_BYTE_ADDR, 16'h0002, 8'h02},
      {ULPD_HIGH_BYTE_ADDR, 16'h0000, 8'h00}};
   always #20 i_clk = ~i_clk;
   ulpd_divisor u_dut (.i_clk, .i_srst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .i_divisor_latch_access_bit(lb), .o_lp_baud_en(en), .o_lp_baud_tick(bt),
      .o_lp_sample_tick(st), .o_pulse_detect_en(pd), .o_settling(sl));
   ////////////////////////////////////////////////////////////////////////////////
   task wr(input logic [31:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task rd(input logic [31:0] a, input logic [15:0] e);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 `CHK(o_rdata, e)
   endtask
   // The task starts part way through a period, so time the span from one tick to the next.
   task time_tick(input int d);
      do @(posedge i_clk); while (bt !== 1'b1);
      n = 0;
      s = 0;
      do begin
         @(posedge i_clk);
         n++;
         s += (st === 1'b1);
      end while (bt !== 1'b1);
      `CHK(n, ULPD_OVERSAMPLE * d)
      `CHK(s, ULPD_OVERSAMPLE)
   endtask
   task report_and_stop;
      $display("checks %0d fails %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge i_clk);
      i_srst <= 1'b0;
      rd(ULPD_LOW_BYTE_ADDR, 16'h0000);
      rd(ULPD_HIGH_BYTE_ADDR, 16'h0000);
      `CHK(en, 1'b0)
      foreach (rows[i]) begin
         wr(rows[i][55:24], rows[i][23:8]);
         rd(rows[i][55:24], {8'h00, rows[i][7:0]});
      end
      $display("rows done");
      `CHK(en, 1'b1)
      `CHK(pd, 1'b1)
      time_tick(2);
      $display("baud done");
      @(posedge i_clk);
      lb <= 1'b0;
      wr(ULPD_LOW_BYTE_ADDR, 16'h0055);
      #1 `CHK(sl, 1'b0)
      rd(ULPD_LOW_BYTE_ADDR, 16'h0000);
      @(posedge i_clk);
      lb <= 1'b1;
      rd(ULPD_LOW_BYTE_ADDR, 16'h0002);
      rd(32'h5000_1028, 16'h0000);
      wr(ULPD_LOW_BYTE_ADDR, 16'h0000);
      repeat (40) @(posedge i_clk);
      `CHK(en, 1'b0)
      `CHK(pd, 1'b0)
      wr(ULPD_HIGH_BYTE_ADDR, {8'h00, lp_div[15:8]});
      #1 `CHK(sl, 1'b1)
      wr(ULPD_LOW_BYTE_ADDR, {8'h00, lp_div[7:0]});
      #1 `CHK(sl, 1'b1)
      // Software holds off for the settling time before it relies on the new rate.
      repeat (ULPD_SETTLE_CYCLES - 1) @(posedge i_clk);
      #1 `CHK(sl, 1'b1)
      @(posedge i_clk);
      #1 `CHK(sl, 1'b0)
      time_tick(lp_div);
      $display("rate done");
      wr(ULPD_LOW_BYTE_ADDR, 16'h0007);
      i_srst <= 1'b1;
      @(posedge i_clk);
      i_srst <= 1'b0;
      rd(ULPD_LOW_BYTE_ADDR, 16'h0000);
      $display("gate and reset done");
      report_and_stop();
   end
   initial begin
      #200us;
      n_fail++;
      report_and_stop();
   end
endmodule // ulpd_divisor_bench

// *** ulpd_pkg.sv ***
package ulpd_pkg;

   // Register byte addresses; both are word aligned.
   localparam logic [31:0] ULPD_LOW_BYTE_ADDR = 32'h5000_1020;
   localparam logic [31:0] ULPD_HIGH_BYTE_ADDR = 32'h5000_1024;

   // Field layout of each latch register.
   localparam int ULPD_FIELD_LSB = 0;
   localparam int ULPD_FIELD_W = 8;
   localparam int ULPD_REG_W = 16;
   localparam int ULPD_DIV_W = 16;

   // Reset values.
   localparam logic [7:0] ULPD_LATCH_RST = 8'h00;

   // Each low-power baud period spans sixteen divisor periods.
   localparam int ULPD_OVERSAMPLE = 16;
   localparam logic [3:0] ULPD_OVS_LAST = 4'hF;

   // Serial clock figures.
   localparam int ULPD_CLK_HZ = 25000000;
   localparam int ULPD_TARGET_BAUD = 115200;

   // Settling time after a latch write, in serial clock cycles.
   localparam int ULPD_SETTLE_CYCLES = 8;
   localparam logic [3:0] ULPD_SETTLE_LOAD = 4'h8;

   typedef struct packed {
      logic [31:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ulpd_bus_req_t;

   typedef struct packed {
      logic baud_en;
      logic baud_tick;
      logic sample_tick;
   } ulpd_baud_t;

endpackage
